// *** core/scs_pkg.sv ***
package scs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS   = 10;
  localparam int unsigned BASE_NS  = 75;
  // least period, so round up to whole cycles
  localparam int unsigned BASE_CYC = (BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SLOW_DIV = 16;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_PARAM    = 6'h00;
  localparam logic [5:0] OFS_CHAR     = 6'h04;
  localparam logic [5:0] OFS_STATUS   = 6'h08;
  localparam logic [5:0] OFS_STROKE   = 6'h0C;
  localparam logic [5:0] OFS_TBL_ADDR = 6'h10;
  localparam logic [5:0] OFS_TBL_DATA = 6'h14;

  // ----------------------------------------------------------------
  // setup word fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BIT_ROT     = 2;
  localparam int unsigned BIT_OS_LOCK = 3;
  localparam int unsigned BIT_SPEED   = 9;
  localparam int unsigned BIT_SP_LOCK = 10;
  localparam logic [1:0]  SIZE_RST    = 2'h3;
  localparam logic        UPRIGHT_RST = 1'h1;
  localparam logic        FAST_RST    = 1'h1;

  // ----------------------------------------------------------------
  // stroke table word
  // ----------------------------------------------------------------
  localparam int unsigned TW_UNBLANK = 7;
  localparam int unsigned TW_SKIP    = 6;
  localparam int unsigned TW_X       = 3;
  localparam int unsigned TW_Y       = 0;
  localparam logic [7:0]  END_WORD   = 8'h80;
  localparam logic [4:0]  ADDR_TOP   = 5'h1F;
  localparam int unsigned TBL_DEPTH  = 4096;

  // ----------------------------------------------------------------
  // status bits
  // ----------------------------------------------------------------
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_CHAR_ENABLE = 1;
  localparam int unsigned ST_NULL = 2;
  localparam int unsigned ST_ADDR = 8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SZ_X3  = 2'h0,
    SZ_X2  = 2'h1,
    SZ_X15 = 2'h2,
    SZ_X1  = 2'h3
  } scs_size_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_RUN  = 2'h2
  } scs_state_e;

endpackage

// *** core/scs_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none


module scs_sequencer
  import scs_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = BASE_CYC,
  parameter int unsigned SLOW_STAGES = SLOW_DIV
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // drive generator controls
  output logic      [3:0]  x_src_o,
  output logic      [3:0]  y_src_o,
  output logic             unblank_o,
  // status lines
  output logic             function_busy_o,
  output logic             char_enable_o,
  output logic             stroke_clock_o,
  output logic             base_stroke_clock_o,
  output logic             null_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // control codes, shift-in and shift-out among them
  function automatic logic is_control(input logic [7:0] c);
    is_control = (c[6:5] == 2'h0) || (c[6:0] == 7'h7F);
  endfunction

  // sign, full, half of one axis to {pos_full, pos_half, neg_full, neg_half}
  function automatic logic [3:0] axis_srcs(input logic [2:0] f);
    axis_srcs = {!f[2] && f[1], !f[2] && f[0], f[2] && f[1], f[2] && f[0]};
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic        ack;
  logic        wr_take;
  logic        rd_take;
  logic [31:0] wd;
  logic [3:0]  be;

  // every access answers after one wait cycle, mapped or not
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
  assign wr_take           = avs_write_i && ack;
  assign rd_take           = avs_read_i && !ack;
  assign wd                = avs_writedata_i;
  assign be                = avs_byteenable_i;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack <= 1'h0;
    end else begin
      ack <= (avs_read_i || avs_write_i) && !ack;
    end
  end

  logic wr_param;
  logic wr_char;
  logic wr_taddr;
  logic wr_tdata;

  assign wr_param = wr_take && (avs_address_i == OFS_PARAM);
  assign wr_char  = wr_take && (avs_address_i == OFS_CHAR) && be[0];
  assign wr_taddr = wr_take && (avs_address_i == OFS_TBL_ADDR);
  assign wr_tdata = wr_take && (avs_address_i == OFS_TBL_DATA) && be[0];

  // ----------------------------------------------------------------
  // display parameter register
  // ----------------------------------------------------------------
  logic [1:0] size;
  logic       upright;
  logic       fast;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      size    <= SIZE_RST;
      upright <= UPRIGHT_RST;
    end else if (wr_param && be[0] && !wd[BIT_OS_LOCK]) begin
      size    <= wd[1:0];
      upright <= wd[BIT_ROT];
    end
  end

  // speed kept apart: its own lock bit in the upper byte
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fast <= FAST_RST;
    end else if (wr_param && be[1] && !wd[BIT_SP_LOCK]) begin
      fast <= wd[BIT_SPEED];
    end
  end

  // ----------------------------------------------------------------
  // stroke table
  // ----------------------------------------------------------------
  logic [7:0]  stroke_mem [TBL_DEPTH];
  logic [11:0] tbl_ptr;
  logic [7:0]  code;
  logic [4:0]  addr;
  logic [7:0]  tbl_word;

  // pair of codes shares one 32-word section
  assign tbl_word = stroke_mem[{code[7:1], addr}];

  always_ff @(posedge clk_i) begin
    if (wr_tdata) begin
      stroke_mem[tbl_ptr] <= wd[7:0];
    end
  end

  // pointer steps after each data write for burst loading
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tbl_ptr <= 12'h000;
    end else if (wr_taddr && be[0] && be[1]) begin
      tbl_ptr <= wd[11:0];
    end else if (wr_tdata) begin
      tbl_ptr <= tbl_ptr + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // character busy control
  // ----------------------------------------------------------------
  scs_state_e state;
  logic       char_take;
  logic       base_tick;
  logic       stroke;
  logic       eoc;
  logic       null_seen;

  // loads during a character are dropped; the controller waits on busy
  assign char_take = wr_char && (state == ST_IDLE);
  assign eoc       = stroke && (tbl_word == END_WORD);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (char_take && !is_control(wd[7:0])) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (base_tick) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (eoc) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // code latch and null indication
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      code      <= 8'h00;
      null_o    <= 1'h0;
      null_seen <= 1'h0;
    end else begin
      null_o <= char_take && is_control(wd[7:0]);
      if (char_take) begin
        code      <= wd[7:0];
        null_seen <= is_control(wd[7:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // address counter and buffer register
  // ----------------------------------------------------------------
  logic [8:0] buf_q;
  logic       skip_q;
  logic [2:0] xf;
  logic [2:0] yf;

  assign xf = tbl_word[TW_X +: 3];
  assign yf = tbl_word[TW_Y +: 3];

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr <= 5'h00;
    end else if (char_take) begin
      addr <= wd[0] ? ADDR_TOP : 5'h00;
    end else if (eoc) begin
      addr <= 5'h00;
    end else if (stroke) begin
      addr <= code[0] ? addr - 5'h01 : addr + 5'h01;
    end
  end

  // rotation: x drive takes negated y, y drive takes x
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      buf_q  <= 9'h000;
      skip_q <= 1'h0;
    end else if (eoc || state == ST_IDLE) begin
      buf_q  <= 9'h000;
      skip_q <= 1'h0;
    end else if (stroke) begin
      skip_q <= tbl_word[TW_SKIP];
      if (upright) begin
        buf_q <= {tbl_word[TW_UNBLANK], axis_srcs(xf), axis_srcs(yf)};
      end else begin
        buf_q <= {tbl_word[TW_UNBLANK], axis_srcs({!yf[2], yf[1:0]}),
                  axis_srcs(xf)};
      end
    end
  end

  assign unblank_o           = buf_q[8];
  assign x_src_o             = buf_q[7:4];
  assign y_src_o             = buf_q[3:0];
  assign function_busy_o     = (state != ST_IDLE);
  assign char_enable_o       = (state == ST_RUN);
  assign stroke_clock_o      = stroke;
  assign base_stroke_clock_o = base_tick;

  // ----------------------------------------------------------------
  // stroke timing
  // ----------------------------------------------------------------
  scs_stroke_clk #(
    .BASE_CYCLES (BASE_CYCLES),
    .SLOW_STAGES (SLOW_STAGES)
  ) u_clk (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .busy_i      (state != ST_IDLE),
    .char_enable_i      (state == ST_RUN),
    .fast_i      (fast),
    .size_i      (size),
    .skip_i      (tbl_word[TW_SKIP]),
    .base_tick_o (base_tick),
    .stroke_o    (stroke)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_take) begin
      avs_readdata_o <= 32'h0000_0000;
      case (avs_address_i)
        OFS_PARAM: begin
          avs_readdata_o[1:0]         <= size;
          avs_readdata_o[BIT_ROT]     <= upright;
          avs_readdata_o[BIT_OS_LOCK] <= 1'h1;
          avs_readdata_o[BIT_SPEED]   <= fast;
          avs_readdata_o[BIT_SP_LOCK] <= 1'h1;
        end
        OFS_CHAR: begin
          avs_readdata_o[7:0] <= code;
        end
        OFS_STATUS: begin
          avs_readdata_o[ST_BUSY]        <= function_busy_o;
          avs_readdata_o[ST_CHAR_ENABLE]        <= char_enable_o;
          avs_readdata_o[ST_NULL]        <= null_seen;
          avs_readdata_o[ST_ADDR +: 5]   <= addr;
        end
        OFS_STROKE: begin
          avs_readdata_o[9:0] <= {skip_q, buf_q};
        end
        OFS_TBL_ADDR: begin
          avs_readdata_o[11:0] <= tbl_ptr;
        end
        OFS_TBL_DATA: begin
          avs_readdata_o[7:0] <= stroke_mem[tbl_ptr];
        end
        default: begin
          avs_readdata_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_os_lock: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_param && wd[BIT_OS_LOCK]) |=> $stable(size) && $stable(upright))
    else $error("locked size or rotate changed");

  a_size_load: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_param && be[0] && !wd[BIT_OS_LOCK]) |=> size == $past(wd[1:0]))
    else $error("size not loaded");

  a_rot_load: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_param && be[0] && !wd[BIT_OS_LOCK]) |=> upright == $past(wd[BIT_ROT]))
    else $error("rotate not loaded");

  a_speed_lock: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_param && wd[BIT_SP_LOCK]) |=> $stable(fast))
    else $error("locked speed changed");

  a_char_start: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (char_take && !is_control(wd[7:0])) |=> function_busy_o && !char_enable_o)
    else $error("printable load did not raise busy");

  a_null_end: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (char_take && is_control(wd[7:0])) |=> null_o && !function_busy_o && $stable(size))
    else $error("control code mishandled");

  a_addr_step: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (stroke && !eoc) |=> addr == ($past(code[0]) ? $past(addr) - 5'h01 : $past(addr) + 5'h01))
    else $error("address did not step");

  a_end_seq: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    eoc |=> !function_busy_o && !char_enable_o && buf_q == 9'h000 && addr == 5'h00)
    else $error("end of character not reset");

  a_readback: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (rd_take && avs_address_i == OFS_PARAM)
      |=> avs_readdata_o[BIT_OS_LOCK] && avs_readdata_o[BIT_SP_LOCK] && !avs_waitrequest_o)
    else $error("parameter readback wrong");

  c_char_done: cover property (@(posedge clk_i) disable iff (!reset_n_i) eoc);
  c_null_code: cover property (@(posedge clk_i) disable iff (!reset_n_i) null_o);
  c_rotated: cover property (@(posedge clk_i) disable iff (!reset_n_i) stroke && !upright);

endmodule

`default_nettype wire

// *** core/scs_stroke_clk.sv ***
`timescale 1ns/1ps
`default_nettype none

module scs_stroke_clk
  import scs_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = BASE_CYC,
  parameter int unsigned SLOW_STAGES = SLOW_DIV
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // control
  input  wire logic       busy_i,
  input  wire logic       char_enable_i,
  input  wire logic       fast_i,
  input  wire logic [1:0] size_i,
  input  wire logic       skip_i,
  // pulses
  output logic            base_tick_o,
  output logic            stroke_o
);

  localparam int unsigned BW = $clog2(BASE_CYCLES + 1);

  logic [BW-1:0] bcnt;
  logic [3:0]    scnt;
  logic [2:0]    dcnt;
  logic [2:0]    div;
  logic          base_pre;
  logic          wrap;
  logic          skip_pend;

  // size code to base ticks per stroke
  function automatic logic [2:0] size_div(input logic [1:0] s);
    case (s)
      SZ_X1:   size_div = 3'h2;
      SZ_X15:  size_div = 3'h3;
      SZ_X2:   size_div = 3'h4;
      default: size_div = 3'h6;
    endcase
  endfunction

  // oscillator model, gated by busy; slow adds a divide-by-16 stage
  assign base_pre    = busy_i && (bcnt == BW'(BASE_CYCLES - 1));
  assign base_tick_o = base_pre && (fast_i || scnt == 4'(SLOW_STAGES - 1));
  assign div         = size_div(size_i);
  assign wrap        = char_enable_i && base_tick_o && (dcnt == div - 3'h1);
  // a pending skip swallows the next pulse
  assign stroke_o    = wrap && !skip_pend;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bcnt <= '0;
      scnt <= 4'h0;
    end else if (!busy_i) begin
      bcnt <= '0;
      scnt <= 4'h0;
    end else if (base_pre) begin
      bcnt <= '0;
      scnt <= (fast_i || scnt == 4'(SLOW_STAGES - 1)) ? 4'h0 : scnt + 4'h1;
    end else begin
      bcnt <= bcnt + BW'(1);
    end
  end

  // stroke divider, cleared while character enable is low
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dcnt      <= 3'h0;
      skip_pend <= 1'h0;
    end else if (!char_enable_i) begin
      dcnt      <= 3'h0;
      skip_pend <= 1'h0;
    end else if (base_tick_o) begin
      dcnt <= wrap ? 3'h0 : dcnt + 3'h1;
      if (wrap) begin
        skip_pend <= skip_pend ? 1'h0 : skip_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [11:0] gap;
  logic [3:0]  tcnt;
  logic        sup;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gap  <= 12'h000;
      tcnt <= 4'h0;
      sup  <= 1'h0;
    end else begin
      gap  <= (!busy_i || base_tick_o) ? 12'h000 : gap + 12'h001;
      tcnt <= (!char_enable_i || stroke_o) ? 4'h0 : tcnt + 4'(base_tick_o);
      sup  <= (!char_enable_i || stroke_o) ? 1'h0 : (sup || (wrap && skip_pend));
    end
  end

  a_fast_period: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (base_tick_o && fast_i) |-> gap == 12'(BASE_CYCLES - 1))
    else $error("fast base tick period wrong");

  a_slow_period: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (base_tick_o && !fast_i) |-> gap == 12'(BASE_CYCLES * SLOW_STAGES - 1))
    else $error("slow base tick period wrong");

  a_stroke_div: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (stroke_o && !sup) |-> (tcnt + 4'h1) == {1'h0, div})
    else $error("stroke period not size divisor");

  a_skip_double: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (stroke_o && sup) |-> (tcnt + 4'h1) == {div, 1'h0})
    else $error("skipped stroke not doubled");

  a_idle_quiet: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !char_enable_i |-> !stroke_o)
    else $error("stroke while not enabled");

  c_skip_taken: cover property (@(posedge clk_i) disable iff (!reset_n_i) stroke_o && sup);
  c_slow_tick: cover property (@(posedge clk_i) disable iff (!reset_n_i) base_tick_o && !fast_i);

endmodule

`default_nettype wire

// *** dv/scs_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------
// controller side: bus master for setup and codes
// ------------------------------------------------
module scs_ctrl_model (
  // clock
  input  wire logic        clk_i,
  // avalon-mm master
  input  wire logic        wait_i,
  output logic      [5:0]  addr_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic      [31:0] data_o
);
  initial {addr_o, rd_o, wr_o, data_o} = '0;

  // request held until wait seen low; char load is a write to CHAR
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    addr_o <= a;
    data_o <= d;
    wr_o   <= w;
    rd_o   <= !w;
    // wait is judged on the rising edge only; release right after that edge
    do @(posedge clk_i); while (wait_i !== 1'b0);
    {rd_o, wr_o} <= 2'h0;
    data_o       <= ~d; // stale data must not look valid
    @(posedge clk_i);
  endtask
endmodule

`default_nettype wire

// *** dv/stroke_character_sequencer_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module stroke_character_sequencer_test;
  import scs_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [5:0]  addr;
  logic        rd, wr, waitreq, busy, char_enable, strk, unb, nul, btick;
  logic [31:0] wdata, rdata, rnd;
  logic [3:0]  xs, ys;
  int          fail_count = 0;
  int          comparisons = 0;
  int          n_str = 0;
  int          n_null = 0;
  int          cnt = 0;
  logic [31:0] q_rd[$];
  int          q_gap[$];
  logic [8:0]  q_drv[$];
  logic [31:0] cfg_w[5] = '{32'h207, 32'h206, 32'h205, 32'h200, 32'h003};
  int          cfg_g[5] = '{4, 6, 8, 12, 8};
  logic [8:0]  cfg_d[5] = '{9'h1C2, 9'h1C2, 9'h1C2, 9'h18C, 9'h18C};

  always #5 clk_i = ~clk_i;

  // short base tick and slow stage keep the run brief
  scs_sequencer #(.BASE_CYCLES(2), .SLOW_STAGES(2)) i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .x_src_o(xs), .y_src_o(ys), .unblank_o(unb), .function_busy_o(busy),
    .char_enable_o(char_enable), .stroke_clock_o(strk), .base_stroke_clock_o(btick), .null_o(nul));

  scs_ctrl_model i_ctrl (
    .clk_i(clk_i), .wait_i(waitreq), .addr_o(addr), .rd_o(rd), .wr_o(wr), .data_o(wdata));

  // ------------------------------------------------
  // compare tasks and verdict
  // ------------------------------------------------
  task automatic cmp_bus(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t bus got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_pin(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t pin got %h exp %h", $time, g, e);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watcher: read data, stroke spacing and first loaded drive word
  always @(posedge clk_i) begin
    cnt = cnt + 1;
    if (rd === 1'b1 && waitreq === 1'b0) cmp_bus(rdata, q_rd.pop_front());
    // base ticks must stay quiet between characters
    if (busy === 1'b0) cmp_pin({31'h0, btick}, 32'h0);
    if (nul === 1'b1) n_null = n_null + 1;
    if (strk === 1'b1) begin
      cmp_pin({31'h0, busy}, 32'h1);
      if (n_str > 0) cmp_pin(cnt, q_gap.pop_front());
      n_str = n_str + 1;
      cnt = 0;
    end else if (n_str == 1 && cnt == 1 && q_drv.size() > 0) begin
      cmp_pin({unb, xs, ys}, q_drv.pop_front());
    end
  end

  task automatic rd_exp(input logic [5:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    i_ctrl.xfer(1'b0, a, 32'h0);
  endtask

  // one character: n strokes, gap g before the skip word doubles it
  task automatic run(input logic [7:0] c, input int n, input int g, input logic [8:0] d);
    n_str = 0;
    if (n > 1) begin
      q_gap.push_back(g);
      q_gap.push_back(2 * g);
      q_drv.push_back(d);
    end
    i_ctrl.xfer(1'b1, OFS_CHAR, {24'h0, c});
    while (busy !== 1'b0) @(negedge clk_i);
    @(posedge clk_i);
    cmp_pin({unb, xs, ys, busy, char_enable}, 32'h0);
    cmp_pin(n_str, n);
  endtask

  initial begin
    #300us;
    fail_count++;
    end_of_test();
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    void'($urandom(32'hea9337e0));
    rnd = $urandom;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rd_exp(OFS_PARAM, 32'h60F);
    rd_exp(6'h20, 32'h0);
    i_ctrl.xfer(1'b1, 6'h20, 32'hFFFF_FFFF);
    i_ctrl.xfer(1'b1, OFS_TBL_ADDR, {20'h0, rnd[11:0]});
    rd_exp(OFS_TBL_ADDR, {20'h0, rnd[11:0]});
    i_ctrl.xfer(1'b1, OFS_TBL_DATA, rnd);
    i_ctrl.xfer(1'b1, OFS_TBL_ADDR, {20'h0, rnd[11:0]});
    rd_exp(OFS_TBL_DATA, {24'h0, rnd[7:0]});
    // pair section: even code words from 0 up, odd code ends at 31
    i_ctrl.xfer(1'b1, OFS_TBL_ADDR, 32'h420);
    i_ctrl.xfer(1'b1, OFS_TBL_DATA, 32'h9E);
    i_ctrl.xfer(1'b1, OFS_TBL_DATA, 32'hDE);
    i_ctrl.xfer(1'b1, OFS_TBL_DATA, 32'h80);
    i_ctrl.xfer(1'b1, OFS_TBL_ADDR, 32'h43F);
    i_ctrl.xfer(1'b1, OFS_TBL_DATA, 32'h80);
    for (int i = 0; i < 5; i++) begin
      i_ctrl.xfer(1'b1, OFS_PARAM, cfg_w[i]);
      rd_exp(OFS_PARAM, cfg_w[i] | 32'h408);
      run(8'h42, 3, cfg_g[i], cfg_d[i]);
    end
    run(8'h43, 1, 0, 9'h0);
    i_ctrl.xfer(1'b1, OFS_PARAM, 32'h408);
    rd_exp(OFS_PARAM, 32'h40B);
    // rotate stays low from the last setup, only speed may change here
    i_ctrl.xfer(1'b1, OFS_PARAM, 32'h208);
    rd_exp(OFS_PARAM, 32'h60B);
    i_ctrl.xfer(1'b1, OFS_PARAM, 32'h404);
    rd_exp(OFS_PARAM, 32'h60C);
    i_ctrl.xfer(1'b1, OFS_CHAR, 32'h0A);
    rd_exp(OFS_STATUS, 32'h4);
    // only the one control code may have pulsed the null line
    cmp_pin(n_null, 1);
    end_of_test();
  end
endmodule

`default_nettype wire
